/* hdl/ctg_clamp_timing.sv */
// clamp window generator with axi4-lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ctg_defines.svh"

module ctg_clamp_timing #(
  parameter int CNT_W = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic [`CTG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`CTG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   line_sync,
  input  wire logic                   clamp_pin,
  output logic                        clamp_window,
  output logic [7:0]                  red_clamp_code,
  output logic [7:0]                  green_clamp_code,
  output logic [7:0]                  blue_clamp_code
);

  // register file and bus handshake state
  logic [7:0]             ctrl_q, ctrl_d;
  logic [CNT_W-1:0]       delay_q, delay_d;
  logic [CNT_W-1:0]       length_q, length_d;
  logic                   aw_have_q, aw_have_d;
  logic                   w_have_q, w_have_d;
  logic [`CTG_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0]             wdata_q, wdata_d;
  logic                   wstrb0_q, wstrb0_d;
  logic                   bvalid_q, bvalid_d;
  logic [1:0]             bresp_q, bresp_d;
  logic                   rvalid_q, rvalid_d;
  logic [1:0]             rresp_q, rresp_d;
  logic [31:0]            rdata_q, rdata_d;

  // window generator state
  ctg_pkg::ctg_state_t    state_q, state_d;
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  logic                   sync_q, sync_d;
  logic                   win_q, win_d;
  logic [7:0]             red_q, red_d, green_q, green_d, blue_q, blue_d;
  logic                   trail;
  logic                   ext_win;

  // register offset decode, shared by both bus directions
  function automatic logic mapped(input logic [`CTG_ADDR_W-1:0] a);
    mapped = (a == `CTG_OFF_CTRL) || (a == `CTG_OFF_DELAY) ||
             (a == `CTG_OFF_LENGTH) || (a == `CTG_OFF_STATUS);
  endfunction

  // clamp target code for one converter
  function automatic logic [7:0] target(input logic mid);
    target = mid ? `CTG_CODE_MID : `CTG_CODE_GROUND;
  endfunction

  // handshakes complete only on enabled edges, so the bus sees the block stall while ce is low
  assign s_axi_awready = ce && !aw_have_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_have_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q && ce;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q && ce;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // bus next state: capture address and data in either order, then write and respond
  always_comb
  begin
    ctrl_d    = ctrl_q;
    delay_d   = delay_q;
    length_d  = length_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(awaddr_q) ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
      if (wstrb0_q)
      begin
        unique case (awaddr_q)
          `CTG_OFF_CTRL:   ctrl_d   = wdata_q;
          `CTG_OFF_DELAY:  delay_d  = wdata_q; // RULE_06
          `CTG_OFF_LENGTH: length_d = wdata_q; // RULE_06
          default:         ;
        endcase
      end
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
      unique case (s_axi_araddr)
        `CTG_OFF_CTRL:   rdata_d = {24'h000000, ctrl_q};
        `CTG_OFF_DELAY:  rdata_d = {24'h000000, delay_q};
        `CTG_OFF_LENGTH: rdata_d = {24'h000000, length_q};
        `CTG_OFF_STATUS: rdata_d = {29'h0, win_q, state_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q    <= `CTG_CTRL_RST; // RULE_09
      delay_q   <= `CTG_DELAY_RST;
      length_q  <= `CTG_LENGTH_RST;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CTG_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= `CTG_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end
    else if (ce)
    begin
      ctrl_q    <= ctrl_d;
      delay_q   <= delay_d;
      length_q  <= length_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // trailing edge is the opposite of the active leading edge chosen by the sense bit
  assign trail = ctrl_q[`CTG_CTRL_SYNC_POL] ? (sync_q && !line_sync)
                                            : (!sync_q && line_sync); // RULE_01 RULE_11
  // external window, level-adjusted, used only while enabled
  assign ext_win = (clamp_pin == ctrl_q[`CTG_CTRL_PIN_POL]); // RULE_03

  // window generator next state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sync_d  = line_sync;
    if (trail)
    begin
      state_d = ctg_pkg::CTG_DELAY; // RULE_12
      cnt_d   = delay_q;
    end
    else
    begin
      unique case (state_q)
        ctg_pkg::CTG_IDLE: ;
        ctg_pkg::CTG_DELAY:
          if (cnt_q == '0)
          begin
            state_d = (length_q == '0) ? ctg_pkg::CTG_IDLE : ctg_pkg::CTG_ACTIVE; // RULE_04
            cnt_d   = length_q;
          end
          else
            cnt_d = cnt_q - 1'b1;
        ctg_pkg::CTG_ACTIVE:
          if (cnt_q <= 1)
          begin
            state_d = ctg_pkg::CTG_IDLE; // RULE_05 RULE_12
            cnt_d   = '0;
          end
          else
            cnt_d = cnt_q - 1'b1;
        default:
          state_d = ctg_pkg::CTG_IDLE;
      endcase
    end
    win_d = ctrl_q[`CTG_CTRL_PIN_EN] ? ext_win
                                     : (state_d == ctg_pkg::CTG_ACTIVE); // RULE_02 RULE_09
    red_d   = target(ctrl_q[`CTG_CTRL_MID_LSB]);   // RULE_10
    green_d = target(ctrl_q[`CTG_CTRL_MID_LSB+1]); // RULE_10
    blue_d  = target(ctrl_q[`CTG_CTRL_MID_LSB+2]); // RULE_10
  end

  // window generator registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ctg_pkg::CTG_IDLE;
      cnt_q   <= '0;
      sync_q  <= 1'b1; // idle level for the reset sense, so no false edge after reset
      win_q   <= 1'b0;
      red_q   <= `CTG_CODE_GROUND;
      green_q <= `CTG_CODE_GROUND;
      blue_q  <= `CTG_CODE_GROUND;
    end
    else if (ce)
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sync_q  <= sync_d;
      win_q   <= win_d;
      red_q   <= red_d;
      green_q <= green_d;
      blue_q  <= blue_d;
    end
  end

  assign clamp_window     = win_q;   // RULE_07
  assign red_clamp_code   = red_q;
  assign green_clamp_code = green_q;
  assign blue_clamp_code  = blue_q;

  // checks
  a_ext_pin_follow: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    ce && ctrl_q[`CTG_CTRL_PIN_EN] && $stable(ctrl_q) |=> win_q == $past(ext_win))
    else $error("window does not follow clamp pin");
  a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    ce && ctrl_q[`CTG_CTRL_PIN_EN] && clamp_pin != ctrl_q[`CTG_CTRL_PIN_POL] |=> !win_q)
    else $error("inactive pin level opened the window");
  a_delay_start: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    ce && trail && delay_q == 8'h00 && length_q != 8'h00 && !ctrl_q[`CTG_CTRL_PIN_EN]
    |=> ce && !trail |=> state_q == ctg_pkg::CTG_ACTIVE)
    else $error("window did not start after zero delay");
  a_active_ends: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    ce && !trail && state_q == ctg_pkg::CTG_ACTIVE && cnt_q == 8'h01
    |=> state_q == ctg_pkg::CTG_IDLE)
    else $error("window did not end when length expired");
  a_trail_restart: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
    ce && trail |=> state_q == ctg_pkg::CTG_DELAY && cnt_q == $past(delay_q))
    else $error("counter not restarted on trailing edge");
  a_pin_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    ce && !ctrl_q[`CTG_CTRL_PIN_EN] |=> win_q == (state_q == ctg_pkg::CTG_ACTIVE))
    else $error("pin used while disabled");
  a_mid_target: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    ce |=> red_q == target($past(ctrl_q[0])) && green_q == target($past(ctrl_q[1]))
      && blue_q == target($past(ctrl_q[2])))
    else $error("clamp target code mismatch");
  a_delay_count: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    ce && !trail && state_q == ctg_pkg::CTG_DELAY && cnt_q != 8'h00
    |=> state_q == ctg_pkg::CTG_DELAY && cnt_q == $past(cnt_q) - 8'h01)
    else $error("delay count not decremented");
  a_bresp_map: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    ce && aw_have_q && w_have_q |=> bvalid_q && (bresp_q == `CTG_RESP_OKAY) == mapped($past(awaddr_q)))
    else $error("write response wrong");

endmodule // ctg_clamp_timing

`default_nettype wire

/* hdl/ctg_defines.svh */
// register offsets, field positions, reset values, clamp codes and bus response codes of the clamp timing generator
// Function
// RULE_01: the line sync input is the timing reference for the clamp window.
// RULE_02: when the external window select bit is 1 the window comes straight from the clamp pin.
// RULE_03: the window input sense bit chooses the active level of the clamp pin.
// RULE_04: internally the window starts after the start-delay count of pixel periods from sync trailing edge.
// RULE_05: internally the window stays active for the window length count of pixel periods.
// RULE_06: start delay and window length are each an eight-bit unsigned value.
// RULE_07: during the window each channel is driven to its clamp target so black converts to code zero.
// RULE_08: software is advised to start with a delay of nine and a length of twenty pixel periods.
// RULE_09: the clamp pin is used only while the pin enable bit is set; it resets to zero.
// RULE_10: each of the three converters has its own midscale or ground clamp target select bit.
// RULE_11: only the leading sync edge is active, falling for sense 0 and rising for sense 1; the code acts on the trailing edge.
// RULE_12: the counters restart on every sync trailing edge and the window ends when length expires.
`ifndef CTG_DEFINES_SVH
`define CTG_DEFINES_SVH

`define CTG_ADDR_W        4
`define CTG_OFF_CTRL      4'h0
`define CTG_OFF_DELAY     4'h4
`define CTG_OFF_LENGTH    4'h8
`define CTG_OFF_STATUS    4'hc

`define CTG_CTRL_PIN_EN   7
`define CTG_CTRL_PIN_POL  6
`define CTG_CTRL_SYNC_POL 5
`define CTG_CTRL_MID_LSB  0

`define CTG_CTRL_RST      8'h00
`define CTG_DELAY_RST     8'h00
`define CTG_LENGTH_RST    8'h00

`define CTG_CODE_GROUND   8'h00
`define CTG_CODE_MID      8'h80

`define CTG_RESP_OKAY     2'b00
`define CTG_RESP_SLVERR   2'b10

`endif

/* hdl/ctg_pkg.sv */
// types of the clamp timing generator
`default_nettype none
package ctg_pkg;
  typedef enum logic [1:0] {
    CTG_IDLE   = 2'b00,
    CTG_DELAY  = 2'b01,
    CTG_ACTIVE = 2'b10
  } ctg_state_t;
endpackage
`default_nettype wire

/* verification/ctg_sync_src.sv */
// graphics source model driving the line sync input
`timescale 1ns/1ps
`default_nettype none

module ctg_sync_src #(
  parameter int PW = 4
) (
  input  wire logic aclk,
  input  wire logic fire,
  input  wire logic sense,
  output logic      line_sync
);
  int cnt_q = 0;

  // sync pulse lasts pw pixel periods, then returns to idle
  always_ff @(posedge aclk)
  begin
    if (fire)
      cnt_q <= PW;
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
  end

  // leading edge falls for sense 0, rises for sense 1
  assign line_sync = (cnt_q > 0) ? sense : ~sense;
endmodule // ctg_sync_src
`default_nettype wire

/* verification/test_ctg_clamp_timing.sv */
// self-checking bench of the clamp timing generator
`timescale 1ns/1ps
`default_nettype none
`include "ctg_defines.svh"

module test_ctg_clamp_timing;
  logic aclk = 0, aresetn = 0, ce = 1, fire = 0, sense = 0, clamp_pin = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, line_sync, clamp_window;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] red_clamp_code, green_clamp_code, blue_clamp_code;
  int failures = 0, total_checks = 0;

  ctg_clamp_timing i_ctg_clamp_timing (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_sync, .clamp_pin, .clamp_window,
    .red_clamp_code, .green_clamp_code, .blue_clamp_code);
  ctg_sync_src i_ctg_sync_src (.aclk, .fire, .sense, .line_sync);

  // pixel clock
  initial
  begin
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // flags are captured mid-cycle, so they equal what the next rising edge samples
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    forever
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready; w = s_axi_wvalid && s_axi_wready; b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) begin s_axi_bready <= 0; break; end
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    forever
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready; v = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 0;
      if (v) begin s_axi_rready <= 0; break; end
    end
  endtask

  // reset values of registers and outputs
  task automatic t_reset();
    logic [31:0] d; logic [1:0] r;
    chk("window", clamp_window, 0);
    chk("red", red_clamp_code, `CTG_CODE_GROUND);
    rd(`CTG_OFF_CTRL, d, r); chk("ctrl", d, `CTG_CTRL_RST);
    rd(`CTG_OFF_DELAY, d, r); chk("delay", d, `CTG_DELAY_RST);
    rd(`CTG_OFF_LENGTH, d, r); chk("length", d, `CTG_LENGTH_RST);
    rd(`CTG_OFF_STATUS, d, r); chk("status", d, 0);
  endtask

  // eight-bit fields, unmapped place, read-only status
  task automatic t_regs();
    logic [31:0] d; logic [1:0] r;
    wr(`CTG_OFF_DELAY, 32'h0000_01a5, r); chk("wr_resp", r, `CTG_RESP_OKAY);
    rd(`CTG_OFF_DELAY, d, r); chk("delay8", d, 32'h0000_00a5);
    s_axi_wstrb <= 4'he;
    wr(`CTG_OFF_DELAY, 32'h0000_0033, r);
    s_axi_wstrb <= 4'hf;
    chk("strb_resp", r, `CTG_RESP_OKAY);
    rd(`CTG_OFF_DELAY, d, r); chk("strb_off", d, 32'h0000_00a5);
    wr(4'h2, 32'h0000_0011, r); chk("bad_wr", r, `CTG_RESP_SLVERR);
    rd(4'h2, d, r); chk("bad_rd", r, `CTG_RESP_SLVERR);
    chk("bad_rd_data", d, 0);
    wr(`CTG_OFF_STATUS, 32'h0000_0007, r);
    chk("ro_resp", r, `CTG_RESP_OKAY);
    rd(`CTG_OFF_STATUS, d, r); chk("status_ro", d, 0);
  endtask

  // per-channel midscale or ground clamp target
  task automatic t_codes();
    logic [1:0] r;
    wr(`CTG_OFF_CTRL, 32'h0000_0005, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("red", red_clamp_code, `CTG_CODE_MID);
    chk("green", green_clamp_code, `CTG_CODE_GROUND);
    chk("blue", blue_clamp_code, `CTG_CODE_MID);
    wr(`CTG_OFF_CTRL, 32'h0000_0002, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("red_g", red_clamp_code, `CTG_CODE_GROUND);
    chk("green_m", green_clamp_code, `CTG_CODE_MID);
  endtask

  // one sync pulse; window start and width measured from its trailing edge
  task automatic sync_win(input int d, input int l);
    int n, w;
    @(posedge aclk); fire <= 1;
    @(posedge aclk); fire <= 0;
    do begin @(posedge aclk); #1; end while (line_sync !== ~sense);
    chk("early_win", clamp_window, 0);
    for (n = 1; n <= d + 20; n++) begin @(posedge aclk); #1; if (clamp_window) break; end
    chk("win_start", n, (l == 0) ? d + 21 : d + 2);
    for (w = 0; clamp_window === 1'b1 && w < 300; w++) begin @(posedge aclk); #1; end
    chk("win_len", w, l);
  endtask

  // internal timing for both sync senses and boundary counts
  task automatic t_internal(input logic s);
    logic [1:0] r;
    wr(`CTG_OFF_CTRL, {26'h0, s, 5'h0}, r);
    sense <= s;
    wr(`CTG_OFF_DELAY, 32'h0000_0009, r);
    wr(`CTG_OFF_LENGTH, 32'h0000_0014, r);
    sync_win(9, 20);
    // second pulse inside the delay must restart the count
    @(posedge aclk); fire <= 1;
    @(posedge aclk); fire <= 0;
    repeat (8) @(posedge aclk);
    sync_win(9, 20);
    wr(`CTG_OFF_DELAY, 32'h0000_0000, r);
    wr(`CTG_OFF_LENGTH, 32'h0000_0001, r);
    sync_win(0, 1);
    wr(`CTG_OFF_LENGTH, 32'h0000_0000, r);
    sync_win(0, 0);
  endtask

  // clock enable low mid-window freezes the length count; one enabled edge passes first
  task automatic t_freeze();
    int n, w;
    logic [1:0] r;
    wr(`CTG_OFF_LENGTH, 32'h0000_0008, r);
    @(posedge aclk); fire <= 1;
    @(posedge aclk); fire <= 0;
    for (n = 0; n < 20 && clamp_window !== 1'b1; n++) begin @(posedge aclk); #1; end
    chk("frz_on", clamp_window, 1);
    @(posedge aclk); ce <= 0;
    repeat (5) @(posedge aclk);
    ce <= 1;
    #1;
    chk("frz_hold", clamp_window, 1);
    for (w = 0; clamp_window === 1'b1 && w < 300; w++) begin @(posedge aclk); #1; end
    chk("frz_len", w, 7);
  endtask

  // external clamp pin, both active levels, and ignored while disabled
  task automatic t_external();
    logic [1:0] r;
    wr(`CTG_OFF_CTRL, 32'h0000_0040, r);
    @(posedge aclk); clamp_pin <= 1;
    repeat (3) @(posedge aclk);
    #1; chk("pin_off", clamp_window, 0);
    for (int p = 0; p < 2; p++)
    begin
      wr(`CTG_OFF_CTRL, 32'h80 | (p << 6), r);
      for (int v = 0; v < 2; v++)
      begin
        @(posedge aclk); clamp_pin <= v[0];
        @(posedge aclk); #1;
        chk("pin_win", clamp_window, v == p);
      end
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reset, then scenarios in turn
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk); #1;
    t_reset();
    t_regs();
    t_codes();
    t_internal(1'b0);
    t_internal(1'b1);
    t_freeze();
    t_external();
    end_sim();
  end

  // watchdog cuts a hang short
  initial
  begin
    #200us;
    failures++;
    end_sim();
  end
endmodule // test_ctg_clamp_timing
`default_nettype wire
